// *** design/ccor_regs.sv ***
// common control registers, backplane clock synthesizer and gapped channel clocks
`timescale 1ns/10ps

// Behaviour
// - backplane clock output low while disabled, toggling at selected rate when enabled.
// - two-bit select picks 16.384, 8.192, 4.096 or 2.048 MHz.
// - backplane clock is phase and frequency locked to the receive line clock.
// - receive gapped enable clocks only selected receive channels on its pin.
// - transmit gapped enable clocks only selected transmit channels, independent of receive.
// - per-direction format bit selects 64k (eight bits) or 56k.
// - 56k format omits the clock for each selected channel's least significant bit.
// - in T1 mode gapped clocks give no pulse at the framing bit.
// - receive cell clock is gated framer clock at 0, receive line clock at 1.
// - transmit cell clock is gated framer clock at 0, transmit line clock at 1.
// - global interrupt disable suppresses the interrupt output, masks untouched.
// - sync source bit picks elastic store at 0, framer or sync pin at 1.
// - four user output bits drive their pins directly.
// - user output pins clear at power-up, hardware reset and software reset.
// - four-bit receive level threshold field, 2.5 dB steps, is presented unchanged.
// - upper five bits of backplane control hold the cell bus port address.
module ccor_regs (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire ccor_pkg::ccor_port_t host_port,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic sw_reset,
    input wire logic t1_mode,
    input wire logic rx_line_clock,
    input wire logic tx_line_clock,
    input wire logic rx_frame_sync,
    input wire logic tx_frame_sync,
    input wire logic tx_sync_pin,
    input wire logic [31:0] rx_frac_select,
    input wire logic [31:0] tx_frac_select,
    input wire logic irq_pending,
    input wire logic es_mf_sync,
    input wire logic framer_mf_sync,
    input wire logic mf_pin_select,
    output logic backplane_clock_out,
    output logic rx_channel_clock,
    output logic tx_channel_clock,
    output logic rx_cell_clock,
    output logic tx_cell_clock,
    output logic irq_n,
    output logic tx_mf_sync,
    output logic [3:0] user_out,
    output logic [3:0] rx_level_thresh,
    output logic [4:0] cell_port_addr
);
    import ccor_pkg::*;

    // ---------------- pin synchronisers ----------------
    ccor_port_t port_s1_reg;
    ccor_port_t port_s2_reg;
    ccor_port_t port_s3_reg;
    ccor_pins_t pins_s1_reg;
    ccor_pins_t pins_s2_reg;
    ccor_pins_t pins_now;

    always_comb begin
        pins_now.rx_clk = rx_line_clock;
        pins_now.tx_clk = tx_line_clock;
        pins_now.rx_fs = rx_frame_sync;
        pins_now.tx_fs = tx_frame_sync;
        pins_now.tx_sync = tx_sync_pin;
    end

    // the third port stage only gives the edge detector a history,
    // and holds address and data from inside the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            port_s1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 8'h00};
            port_s2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 8'h00};
            port_s3_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 8'h00, wdata: 8'h00};
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
        end else begin
            port_s1_reg <= host_port;
            port_s2_reg <= port_s1_reg;
            port_s3_reg <= port_s2_reg;
            pins_s1_reg <= pins_now;
            pins_s2_reg <= pins_s1_reg;
        end
    end

    // ---------------- register file ----------------
    logic [7:0] bp_ctrl_reg;
    logic [7:0] bp_ctrl_next;
    logic [7:0] ch_ctrl_reg;
    logic [7:0] ch_ctrl_next;
    logic [7:0] user_ctrl_reg;
    logic [7:0] user_ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic oe_reg;
    logic oe_next;
    logic wr_event;

    // write takes effect when the strobe is released, with cs still asserted
    assign wr_event = !port_s3_reg.wr_n && port_s2_reg.wr_n && !port_s3_reg.cs_n;

    always_comb begin
        bp_ctrl_next = bp_ctrl_reg;
        ch_ctrl_next = ch_ctrl_reg;
        user_ctrl_next = user_ctrl_reg;
        // software reset beats a write landing in the same cycle
        if (sw_reset) begin
            bp_ctrl_next = CCOR_REG_RESET;
            ch_ctrl_next = CCOR_REG_RESET;
            user_ctrl_next = CCOR_REG_RESET;
        end else if (wr_event) begin
            unique case (port_s3_reg.addr)
                CCOR_BP_CTRL_ADDR: bp_ctrl_next = port_s3_reg.wdata;
                CCOR_CH_CTRL_ADDR: ch_ctrl_next = port_s3_reg.wdata;
                CCOR_USER_CTRL_ADDR: user_ctrl_next = port_s3_reg.wdata;
                default: ;
            endcase
        end
        // reads use the second stage; only the write edge needs the older third stage
        oe_next = !port_s2_reg.cs_n && !port_s2_reg.rd_n;
        unique case (port_s2_reg.addr)
            CCOR_BP_CTRL_ADDR: rdata_next = bp_ctrl_reg;
            CCOR_CH_CTRL_ADDR: rdata_next = ch_ctrl_reg;
            CCOR_USER_CTRL_ADDR: rdata_next = user_ctrl_reg;
            default: rdata_next = CCOR_UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bp_ctrl_reg <= CCOR_REG_RESET;
            ch_ctrl_reg <= CCOR_REG_RESET;
            user_ctrl_reg <= CCOR_REG_RESET;
            rdata_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            bp_ctrl_reg <= bp_ctrl_next;
            ch_ctrl_reg <= ch_ctrl_next;
            user_ctrl_reg <= user_ctrl_next;
            rdata_reg <= rdata_next;
            oe_reg <= oe_next;
        end
    end

    assign host_data_out = rdata_reg;
    assign host_data_oe = oe_reg;
    assign user_out = user_ctrl_reg[CCOR_USER_OUT_LSB +: 4];
    assign rx_level_thresh = user_ctrl_reg[CCOR_LEVEL_LSB +: 4];
    assign cell_port_addr = bp_ctrl_reg[CCOR_CELL_ADDR_LSB +: 5];

    // ---------------- interrupt gate and multiframe sync source ----------------
    logic irq_n_reg;
    logic irq_n_next;
    logic mf_reg;
    logic mf_next;

    always_comb begin
        // only the global gate lives here; the individual masks act before irq_pending
        irq_n_next = !(irq_pending && !ch_ctrl_reg[CCOR_IRQ_DIS_BIT]);
        if (ch_ctrl_reg[CCOR_MF_SRC_BIT]) begin
            mf_next = mf_pin_select ? pins_s2_reg.tx_sync : framer_mf_sync;
        end else begin
            mf_next = es_mf_sync;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_n_reg <= 1'b1;
            mf_reg <= 1'b0;
        end else begin
            irq_n_reg <= irq_n_next;
            mf_reg <= mf_next;
        end
    end

    assign irq_n = irq_n_reg;
    assign tx_mf_sync = mf_reg;

    // ---------------- backplane clock synthesizer ----------------
    // the line clock is sampled at the reference rate, so output is limited to
    // half the reference clock; faster selections saturate at one cycle per half
    logic rx_prev_reg;
    logic rx_prev_next;
    logic rx_rise;
    logic [7:0] per_cnt_reg;
    logic [7:0] per_cnt_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [7:0] half_cnt_reg;
    logic [7:0] half_cnt_next;
    logic [7:0] half_len;
    logic [2:0] half_shift;
    logic bp_out_reg;
    logic bp_out_next;

    assign rx_rise = pins_s2_reg.rx_clk && !rx_prev_reg;

    always_comb begin
        rx_prev_next = pins_s2_reg.rx_clk;
        per_cnt_next = per_cnt_reg;
        period_next = period_reg;
        half_cnt_next = half_cnt_reg;
        bp_out_next = bp_out_reg;
        half_shift = CCOR_BP_SHIFT_BASE - {1'b0, bp_ctrl_reg[CCOR_BP_FSEL_LSB +: 2]};
        half_len = period_reg >> half_shift;
        // before the first measured line edge the period is 0, so the output runs fast
        if (half_len == 8'h00) begin
            half_len = 8'h01;
        end
        // measure the line period in reference cycles; the counter saturates, so a period of 256 or more reads as 0
        if (rx_rise) begin
            period_next = per_cnt_reg + 8'h01;
            per_cnt_next = 8'h00;
        end else if (per_cnt_reg != 8'hff) begin
            per_cnt_next = per_cnt_reg + 8'h01;
        end
        if (!bp_ctrl_reg[CCOR_BP_EN_BIT]) begin
            bp_out_next = 1'b0;
            half_cnt_next = 8'h00;
        end else if (rx_rise) begin
            // re-phase on every line edge keeps the output locked
            bp_out_next = 1'b1;
            half_cnt_next = 8'h00;
        end else if (half_cnt_reg + 8'h01 >= half_len) begin
            bp_out_next = !bp_out_reg;
            half_cnt_next = 8'h00;
        end else begin
            half_cnt_next = half_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_prev_reg <= 1'b0;
            per_cnt_reg <= 8'h00;
            period_reg <= 8'h00;
            half_cnt_reg <= 8'h00;
            bp_out_reg <= 1'b0;
        end else begin
            rx_prev_reg <= rx_prev_next;
            per_cnt_reg <= per_cnt_next;
            period_reg <= period_next;
            half_cnt_reg <= half_cnt_next;
            bp_out_reg <= bp_out_next;
        end
    end

    assign backplane_clock_out = bp_out_reg;

    // ---------------- channel clocks, index 0 receive, 1 transmit ----------------
    ccor_chan_cfg_t cfg [2];
    logic line_clk [2];
    logic line_fs [2];
    logic [31:0] frac_sel [2];
    logic chan_clk_q [2];
    logic cell_clk_q [2];

    always_comb begin
        cfg[0].gap_en = ch_ctrl_reg[CCOR_RX_GAP_EN_BIT];
        cfg[0].fmt56 = ch_ctrl_reg[CCOR_RX_FMT_BIT];
        cfg[0].cell_sel = ch_ctrl_reg[CCOR_RX_CELL_SEL_BIT];
        cfg[1].gap_en = ch_ctrl_reg[CCOR_TX_GAP_EN_BIT];
        cfg[1].fmt56 = ch_ctrl_reg[CCOR_TX_FMT_BIT];
        cfg[1].cell_sel = ch_ctrl_reg[CCOR_TX_CELL_SEL_BIT];
        line_clk[0] = pins_s2_reg.rx_clk;
        line_clk[1] = pins_s2_reg.tx_clk;
        line_fs[0] = pins_s2_reg.rx_fs;
        line_fs[1] = pins_s2_reg.tx_fs;
        frac_sel[0] = rx_frac_select;
        frac_sel[1] = tx_frac_select;
    end

    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_dir
            logic clk_prev_reg;
            logic [8:0] pos_reg;
            logic [8:0] pos_next;
            logic [8:0] slot;
            logic fbit;
            logic gate;
            logic chan_next;
            logic cell_next;
            logic chan_reg;
            logic cell_reg;
            logic line_rise;
            logic [8:0] last_pos;

            always_comb begin
                pos_next = pos_reg;
                line_rise = line_clk[d] && !clk_prev_reg;
                last_pos = t1_mode ? CCOR_T1_LAST_POS : CCOR_E1_LAST_POS;
                // frame sync beats the wrap, so a moved frame realigns on its first bit
                if (line_rise) begin
                    if (line_fs[d]) begin
                        pos_next = 9'h000;
                    end else if (pos_reg == last_pos) begin
                        pos_next = 9'h000;
                    end else begin
                        pos_next = pos_reg + 9'h001;
                    end
                end
                // gating looks at the new position so it lines up with the high phase
                fbit = t1_mode && (pos_next == 9'h000);
                slot = t1_mode ? pos_next - 9'h001 : pos_next;
                gate = frac_sel[d][slot[7:3]] && !fbit;
                if (cfg[d].fmt56 && (slot[2:0] == CCOR_LSB_POS)) begin
                    gate = 1'b0;
                end
                if (cfg[d].gap_en) begin
                    chan_next = gate && line_clk[d];
                end else begin
                    // normal function: one pulse per channel over its first half
                    chan_next = !fbit && (slot[2:0] < CCOR_HALF_CHAN);
                end
                // select changes in the high phase give a short pulse; change it while low
                cell_next = cfg[d].cell_sel ? line_clk[d] : (gate && line_clk[d]);
            end

            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    clk_prev_reg <= 1'b0;
                    pos_reg <= 9'h000;
                    chan_reg <= 1'b0;
                    cell_reg <= 1'b0;
                end else begin
                    clk_prev_reg <= line_clk[d];
                    pos_reg <= pos_next;
                    chan_reg <= chan_next;
                    cell_reg <= cell_next;
                end
            end

            assign chan_clk_q[d] = chan_reg;
            assign cell_clk_q[d] = cell_reg;
        end
    endgenerate

    assign rx_channel_clock = chan_clk_q[0];
    assign tx_channel_clock = chan_clk_q[1];
    assign rx_cell_clock = cell_clk_q[0];
    assign tx_cell_clock = cell_clk_q[1];

endmodule

// *** include/ccor_pkg.sv ***
// constants and carrier types for the common control and clock output register bank
package ccor_pkg;

    // register byte addresses on the parallel port
    localparam logic [7:0] CCOR_BP_CTRL_ADDR = 8'h71;
    localparam logic [7:0] CCOR_CH_CTRL_ADDR = 8'h72;
    localparam logic [7:0] CCOR_USER_CTRL_ADDR = 8'h73;
    localparam logic [7:0] CCOR_REG_RESET = 8'h00;
    localparam logic [7:0] CCOR_UNMAPPED_DATA = 8'h00;

    // backplane_clock_control fields
    localparam int CCOR_BP_EN_BIT = 0;
    localparam int CCOR_BP_FSEL_LSB = 1;
    localparam int CCOR_CELL_ADDR_LSB = 3;

    // channel_clock_control fields
    localparam int CCOR_RX_GAP_EN_BIT = 0;
    localparam int CCOR_RX_FMT_BIT = 1;
    localparam int CCOR_TX_GAP_EN_BIT = 2;
    localparam int CCOR_TX_FMT_BIT = 3;
    localparam int CCOR_RX_CELL_SEL_BIT = 4;
    localparam int CCOR_TX_CELL_SEL_BIT = 5;
    localparam int CCOR_IRQ_DIS_BIT = 6;
    localparam int CCOR_MF_SRC_BIT = 7;

    // user_output_control fields
    localparam int CCOR_USER_OUT_LSB = 0;
    localparam int CCOR_LEVEL_LSB = 4;

    // frequency select: 00 16.384, 01 8.192, 10 4.096, 11 2.048 MHz;
    // half period of the output is the line period shifted right by (base - code)
    localparam logic [2:0] CCOR_BP_SHIFT_BASE = 3'h4;

    // frame geometry
    localparam logic [8:0] CCOR_T1_LAST_POS = 9'h0c0;
    localparam logic [8:0] CCOR_E1_LAST_POS = 9'h0ff;
    localparam logic [2:0] CCOR_LSB_POS = 3'h7;
    localparam logic [2:0] CCOR_HALF_CHAN = 3'h4;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccor_port_t;

    typedef struct packed {
        logic rx_clk;
        logic tx_clk;
        logic rx_fs;
        logic tx_fs;
        logic tx_sync;
    } ccor_pins_t;

    typedef struct packed {
        logic gap_en;
        logic fmt56;
        logic cell_sel;
    } ccor_chan_cfg_t;

endpackage

// *** sim/ccor_line_model.sv ***
// far side model: line clocks, frame syncs and per-frame pulse counts of the clock pins
`timescale 1ns/10ps
module ccor_line_model (
    input wire logic t1_mode,
    input wire logic [3:0] clks,
    output logic rx_line_clock,
    output logic tx_line_clock,
    output logic rx_frame_sync,
    output logic tx_frame_sync,
    output logic [3:0][8:0] frame_cnt
);
    import ccor_pkg::*;
    logic [8:0] rx_pos = 9'h000;
    logic [8:0] tx_pos = 9'h000;
    logic [8:0] last;
    int tot [4] = '{0, 0, 0, 0};
    int mark [4] = '{0, 0, 0, 0};
    assign last = t1_mode ? CCOR_T1_LAST_POS : CCOR_E1_LAST_POS;
    initial begin
        {rx_line_clock, tx_line_clock, rx_frame_sync, tx_frame_sync} = 4'h0;
        frame_cnt = '0;
    end
    always #200 rx_line_clock = ~rx_line_clock;
    // transmit side keeps a phase of its own
    initial begin
        #70;
        forever #200 tx_line_clock = ~tx_line_clock;
    end
    // sync moves on the falling edge so it is steady at the rising edge of position 0
    always @(negedge rx_line_clock) begin
        rx_pos <= (rx_pos >= last) ? 9'h000 : rx_pos + 9'h001;
        rx_frame_sync <= (rx_pos >= last);
    end
    always @(negedge tx_line_clock) begin
        tx_pos <= (tx_pos >= last) ? 9'h000 : tx_pos + 9'h001;
        tx_frame_sync <= (tx_pos >= last);
    end
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        always @(posedge clks[i]) tot[i]++;
    end
    always @(posedge rx_line_clock) if (rx_frame_sync) begin
        for (int i = 0; i < 4; i += 2) begin
            frame_cnt[i] <= 9'(tot[i] - mark[i]);
            mark[i] = tot[i];
        end
    end
    always @(posedge tx_line_clock) if (tx_frame_sync) begin
        for (int i = 1; i < 4; i += 2) begin
            frame_cnt[i] <= 9'(tot[i] - mark[i]);
            mark[i] = tot[i];
        end
    end
endmodule

// *** sim/ccor_regs_properties.sv ***
// assertion checker for the common control register bank
`timescale 1ns/10ps
module ccor_regs_properties (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire ccor_pkg::ccor_port_t host_port,
    input wire logic host_data_oe,
    input wire logic sw_reset,
    input wire logic rx_line_clock,
    input wire logic tx_line_clock,
    input wire logic irq_pending,
    input wire logic rx_cell_clock,
    input wire logic tx_cell_clock,
    input wire logic irq_n,
    input wire logic [3:0] user_out,
    input wire logic [3:0] rx_level_thresh,
    input wire logic [4:0] cell_port_addr
);
    import ccor_pkg::*;
    logic rd_on;
    logic [12:0] regs;
    assign rd_on = !host_port.cs_n && !host_port.rd_n;
    assign regs = {user_out, rx_level_thresh, cell_port_addr};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_oe_cause: assert property (host_data_oe |-> $past(rd_on, 3))
        else $error("data bus driven without a read strobe");
    a_oe_stands: assert property ($past(rd_on, 3) && $past(rd_on, 4) |-> host_data_oe)
        else $error("read data not driven during read strobe");
    a_sw_clear: assert property (sw_reset |=> regs == 13'h0000)
        else $error("software reset left register outputs set");
    // strobes pass two sync flops, so the update lands four or five edges after the rise
    a_reg_cause: assert property ($changed(regs) |-> $past(sw_reset)
        || ($past(host_port.wr_n, 3) && !$past(host_port.wr_n, 4))
        || ($past(host_port.wr_n, 4) && !$past(host_port.wr_n, 5)))
        else $error("register outputs changed without a write");
    a_irq_idle: assert property (!irq_pending |=> irq_n)
        else $error("interrupt asserted with nothing pending");
    a_rx_cell_edge: assert property ($rose(rx_cell_clock) |->
        $past(rx_line_clock, 3) && !$past(rx_line_clock, 4))
        else $error("receive cell clock rose off a line clock edge");
    a_rx_cell_level: assert property (rx_cell_clock |-> $past(rx_line_clock, 3))
        else $error("receive cell clock high in line clock low phase");
    a_tx_cell_level: assert property (tx_cell_clock |-> $past(tx_line_clock, 3))
        else $error("transmit cell clock high in line clock low phase");
endmodule

bind ccor_regs ccor_regs_properties u_props (.ref_clk, .rstn, .host_port, .host_data_oe,
    .sw_reset, .rx_line_clock, .tx_line_clock, .irq_pending, .rx_cell_clock, .tx_cell_clock,
    .irq_n, .user_out, .rx_level_thresh, .cell_port_addr);

// *** sim/ccor_regs_tb.sv ***
// self-checking bench for the common control register bank
`timescale 1ns/10ps
module ccor_regs_tb;
    import ccor_pkg::*;
    localparam logic [5:0] MF_ROWS [6] = '{6'h09, 6'h06, 6'h25, 6'h2a, 6'h33, 6'h3c};
    localparam int BP_EXP [5] = '{40, 40, 20, 10, 0};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    ccor_port_t host_port = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
    logic sw_reset = 1'b0, t1_mode = 1'b0, tx_sync_pin = 1'b0, irq_pending = 1'b0;
    logic es_mf_sync = 1'b0, framer_mf_sync = 1'b0, mf_pin_select = 1'b0;
    logic [31:0] rx_frac_select = 32'h0, tx_frac_select = 32'h0;
    logic [7:0] host_data_out;
    logic host_data_oe, rx_line_clock, tx_line_clock, rx_frame_sync, tx_frame_sync;
    logic backplane_clock_out, rx_channel_clock, tx_channel_clock, rx_cell_clock;
    logic tx_cell_clock, irq_n, tx_mf_sync;
    logic [3:0] user_out, rx_level_thresh;
    logic [4:0] cell_port_addr;
    logic [3:0][8:0] frame_cnt;
    int miscompares = 0;
    int checks_done = 0;
    ccor_regs u_dut (.ref_clk, .rstn, .host_port, .host_data_out, .host_data_oe, .sw_reset,
        .t1_mode, .rx_line_clock, .tx_line_clock, .rx_frame_sync, .tx_frame_sync, .tx_sync_pin,
        .rx_frac_select, .tx_frac_select, .irq_pending, .es_mf_sync, .framer_mf_sync,
        .mf_pin_select, .backplane_clock_out, .rx_channel_clock, .tx_channel_clock,
        .rx_cell_clock, .tx_cell_clock, .irq_n, .tx_mf_sync, .user_out, .rx_level_thresh,
        .cell_port_addr);
    ccor_line_model u_model (.t1_mode, .rx_line_clock, .tx_line_clock, .rx_frame_sync,
        .clks({tx_cell_clock, rx_cell_clock, tx_channel_clock, rx_channel_clock}),
        .tx_frame_sync, .frame_cnt);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // strobes and data are held well past the two-flop sync on each side of the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_port = '{1'b0, 1'b1, 1'b0, a, d};
        tick(3);
        // release in the receive line low phase so a select change makes no mid-phase rise
        @(negedge rx_line_clock);
        tick(1);
        host_port.wr_n = 1'b1;
        tick(3);
        host_port = '{1'b1, 1'b1, 1'b1, ~a, ~d};
        tick(4);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        host_port = '{1'b0, 1'b0, 1'b1, a, 8'h00};
        tick(5);
        chk("host_data_oe", 16'h1, 16'(host_data_oe));
        chk(nm, 16'(exp), 16'(host_data_out));
        host_port = '{1'b1, 1'b1, 1'b1, ~a, 8'hff};
        tick(4);
    endtask
    task automatic t_regs;
        chk("user_out", 16'h0, 16'(user_out));
        rd(CCOR_BP_CTRL_ADDR, CCOR_REG_RESET, "bp reg");
        rd(CCOR_CH_CTRL_ADDR, CCOR_REG_RESET, "ch reg");
        for (int i = 0; i < 16; i++) begin
            wr(CCOR_USER_CTRL_ADDR, {4'(i), 4'(15 - i)});
            chk("user_out", 16'(15 - i), 16'(user_out));
            chk("rx_level_thresh", 16'(i), 16'(rx_level_thresh));
        end
        wr(8'h74, 8'h5a);
        rd(CCOR_USER_CTRL_ADDR, 8'hf0, "user reg");
        rd(8'h74, CCOR_UNMAPPED_DATA, "unmapped");
        wr(CCOR_BP_CTRL_ADDR, 8'ha8);
        chk("cell_port_addr", 16'h15, 16'(cell_port_addr));
        wr(CCOR_CH_CTRL_ADDR, 8'h96);
        rd(CCOR_BP_CTRL_ADDR, 8'ha8, "bp reg");
        rd(CCOR_CH_CTRL_ADDR, 8'h96, "ch reg");
        sw_reset = 1'b1;
        tick(1);
        sw_reset = 1'b0;
        tick(1);
        chk("user_out", 16'h0, 16'(user_out));
        rd(CCOR_USER_CTRL_ADDR, CCOR_REG_RESET, "user reg");
    endtask
    task automatic t_irq;
        irq_pending = 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(CCOR_CH_CTRL_ADDR, (i == 1) ? 8'h40 : 8'h00);
            chk("irq_n", 16'(i == 1), 16'(irq_n));
        end
        irq_pending = 1'b0;
    endtask
    task automatic t_mf;
        for (int i = 0; i < 6; i++) begin
            {mf_pin_select, es_mf_sync, framer_mf_sync, tx_sync_pin} = MF_ROWS[i][4:1];
            wr(CCOR_CH_CTRL_ADDR, {MF_ROWS[i][5], 7'h00});
            chk("tx_mf_sync", 16'(MF_ROWS[i][0]), 16'(tx_mf_sync));
        end
    endtask
    // rises over ten line periods; one either way allowed for the window edges
    task automatic t_bp;
        int n;
        logic p;
        for (int s = 0; s < 5; s++) begin
            wr(CCOR_BP_CTRL_ADDR, (s < 4) ? {5'h15, 2'(s), 1'b1} : 8'h06);
            n = 0;
            p = backplane_clock_out;
            for (int c = 0; c < 80; c++) begin
                tick(1);
                if (backplane_clock_out === 1'b1 && p !== 1'b1) n++;
                p = backplane_clock_out;
            end
            chk("bp rises", 16'h1, 16'(n >= BP_EXP[s] - 1 && n <= BP_EXP[s] + 1));
            if (s == 4) begin
                chk("bp level", 16'h0, 16'(backplane_clock_out));
            end
        end
    endtask
    task automatic t_chan(input logic t1, input logic [7:0] cfg, input logic [31:0] rs,
        input logic [31:0] ts, input logic [3:0][8:0] exp);
        // mode and selects move the gate at once, so change them in the line low phase
        @(negedge rx_line_clock);
        tick(2);
        t1_mode = t1;
        rx_frac_select = rs;
        tx_frac_select = ts;
        wr(CCOR_CH_CTRL_ADDR, cfg);
        repeat (3) @(posedge rx_line_clock iff rx_frame_sync === 1'b1);
        tick(20);
        for (int i = 0; i < 4; i++) begin
            chk($sformatf("pulse count %0d", i), 16'(exp[i]), 16'(frame_cnt[i]));
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        rstn = 1'b1;
        tick(2);
        t_regs;
        t_irq;
        t_mf;
        t_bp;
        t_chan(1'b0, 8'h05, 32'ha, 32'h1, {9'h008, 9'h010, 9'h008, 9'h010});
        t_chan(1'b0, 8'h3f, 32'ha, 32'h1, {9'h100, 9'h100, 9'h007, 9'h00e});
        t_chan(1'b0, 8'h04, 32'ha, 32'h1, {9'h008, 9'h010, 9'h008, 9'h020});
        t_chan(1'b1, 8'h00, 32'h1, 32'h1, {9'h008, 9'h008, 9'h018, 9'h018});
        t_chan(1'b1, 8'h0f, 32'hffffff, 32'h800000, {9'h007, 9'h0a8, 9'h007, 9'h0a8});
        test_done;
    end
    initial begin
        #4000000;
        miscompares++;
        test_done;
    end
endmodule
